// file: hs_pkg.sv
// constants and types shared by the high-side switch control files
package hs_pkg;
  // clock and timing
  localparam int CLK_KHZ = 25000;
  localparam int SD_FILTER_MIN_NS = 12000;
  localparam int SD_FILTER_MAX_NS = 20000;
  localparam int OL_FILTER_TYP_NS = 64000;
  localparam int OC_CYCLES = (SD_FILTER_MIN_NS * CLK_KHZ + 999999) / 1000000;
  localparam int OL_CYCLES = (OL_FILTER_TYP_NS * CLK_KHZ) / 1000000;
  localparam logic [10:0] OC_CNT_LAST = 11'(OC_CYCLES - 1);
  localparam logic [10:0] OL_CNT_LAST = 11'(OL_CYCLES - 1);
  localparam int PWM_SLOW_HZ = 200;
  localparam int PWM_FAST_HZ = 400;
  localparam int PWM_STEPS = 256;
  localparam int STEP_SLOW_CYCLES = (CLK_KHZ * 1000) / (PWM_SLOW_HZ * PWM_STEPS);
  localparam int STEP_FAST_CYCLES = (CLK_KHZ * 1000) / (PWM_FAST_HZ * PWM_STEPS);
  localparam logic [8:0] STEP_SLOW_LAST = 9'(STEP_SLOW_CYCLES - 1);
  localparam logic [8:0] STEP_FAST_LAST = 9'(STEP_FAST_CYCLES - 1);
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_PWM_A = 8'h08;
  localparam logic [7:0] ADDR_PWM_B = 8'h0c;
  localparam logic [7:0] ADDR_FREQ = 8'h10;
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h14;
  localparam logic [7:0] ADDR_SUPPLY_STAT = 8'h18;
  localparam logic [7:0] ADDR_OC_STAT = 8'h1c;
  localparam logic [7:0] ADDR_OL_STAT = 8'h20;
  // field positions
  localparam int CH_LO_LSB = 0;
  localparam int CH_HI_LSB = 4;
  localparam int OV_SD_DIS_BIT = 0;
  localparam int UV_SD_DIS_BIT = 1;
  localparam int RECOVERY_BIT = 2;
  localparam int OV_FLAG_BIT = 0;
  localparam int UV_FLAG_BIT = 1;
  // channel configuration codes
  localparam logic [2:0] CFG_OFF = 3'h0;
  localparam logic [2:0] CFG_ON = 3'h1;
  localparam logic [2:0] CFG_TIMER1 = 3'h2;
  localparam logic [2:0] CFG_TIMER2 = 3'h3;
  localparam logic [2:0] CFG_PWM_A = 3'h4;
  localparam logic [2:0] CFG_PWM_B = 3'h5;
  // reset values
  localparam logic [2:0] RST_CFG = 3'h0;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [1:0] RST_FREQ = 2'h0;
  localparam logic [2:0] RST_SUPPLY_CTRL = 3'h0;
  // operating modes of the surrounding chip
  typedef enum logic [4:0] {
    MODE_NORMAL = 5'b00001,
    MODE_STOP = 5'b00010,
    MODE_SLEEP = 5'b00100,
    MODE_RESTART = 5'b01000,
    MODE_FAILSAFE = 5'b10000
  } mode_t;
endpackage

// file: hs_pwm_if.sv
// carrier between the control logic and one pwm generator
`timescale 1ns/1ps
interface hs_pwm_if;
  logic [7:0] duty;
  logic fast;
  logic wave;
  modport gen (input duty, input fast, output wave);
  modport ctl (output duty, output fast, input wave);
endinterface

// file: hs_pwm_gen.sv
// one 8-bit pwm generator, 200 or 400 hz
`timescale 1ns/1ps
module hs_pwm_gen (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  hs_pwm_if.gen pwm
);
  import hs_pkg::*;

  logic [8:0] step_cnt;
  logic [7:0] phase;
  wire logic [8:0] step_last;
  wire logic step_en;

  // step divider, period split in 256 steps
  assign step_last = pwm.fast ? STEP_FAST_LAST : STEP_SLOW_LAST;
  assign step_en = (step_cnt >= step_last);

  // step divider
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || step_en) begin
      step_cnt <= 9'h000;
    end else begin
      step_cnt <= step_cnt + 9'h001;
    end
  end

  // phase within period
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      phase <= 8'h00;
    end else if (step_en) begin
      phase <= phase + 8'h01;
    end
  end

  // high for duty steps from period start; duty 1 is shorter than the switch edges
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwm.wave <= 1'b0;
    end else begin
      pwm.wave <= (phase < pwm.duty);
    end
  end
endmodule

// file: high_side_switch_control.sv
// control logic for four high-side switches with apb registers
`timescale 1ns/1ps
// Summary of operation
// - overvoltage turns outputs off unless disabled
// - undervoltage turns outputs off unless disabled
// - recovery bit restores, else configs cleared
// - supply faults only set supply flags
// - overcurrent past filter time switches off
// - overcurrent sets flag, config to off
// - overcurrent flags cleared only by software
// - open load checked while on, filtered
// - open load keeps output on, sticky flag
// - configuration locked in stop and sleep
// - restart or fail-safe switches all off
// - protections stay active in stop, sleep
// - two pwm generators, 8-bit duty each
// - per generator 200 or 400 hz
// - each output selects its source
// - pwm drives output at once when assigned
// - duty one too short for switch
module high_side_switch_control (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire hs_pkg::mode_t i_sbc_mode,
  input wire logic i_supply_ov,
  input wire logic i_supply_uv,
  input wire logic [3:0] i_overcurrent,
  input wire logic [3:0] i_open_load,
  input wire logic i_timer1,
  input wire logic i_timer2,
  output logic [3:0] o_switch_output
);
  import hs_pkg::*;

  logic [2:0] cfg [4];
  logic [2:0] next_cfg [4];
  logic [7:0] duty_a;
  logic [7:0] duty_b;
  logic [1:0] freq_sel;
  logic [2:0] supply_ctrl;
  logic [1:0] supply_flag;
  logic [3:0] oc_flag;
  logic [3:0] ol_flag;
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic vfault_q;
  logic off_mode_q;
  logic [3:0] oc_trip;
  logic [3:0] ol_trip;
  logic [3:0] source_on;
  logic [3:0] drive;

  hs_pwm_if pwm_a_if ();
  hs_pwm_if pwm_b_if ();

  // two pwm generators
  assign pwm_a_if.duty = duty_a;
  assign pwm_a_if.fast = freq_sel[0];
  assign pwm_b_if.duty = duty_b;
  assign pwm_b_if.fast = freq_sel[1];

  hs_pwm_gen u_pwm_a (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .pwm(pwm_a_if)
  );

  hs_pwm_gen u_pwm_b (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .pwm(pwm_b_if)
  );

  // comparator levels gathered for the synchroniser
  wire logic [9:0] pin_raw = {i_open_load, i_overcurrent, i_supply_uv, i_supply_ov};

  // analog comparator inputs pass two flops
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire logic ov_s = pin_sync[0];
  wire logic uv_s = pin_sync[1];
  wire logic [3:0] oc_s = pin_sync[5:2];
  wire logic [3:0] ol_s = pin_sync[9:6];

  // operating mode decode
  wire logic in_stop = (i_sbc_mode == MODE_STOP);
  wire logic in_sleep = (i_sbc_mode == MODE_SLEEP);
  wire logic in_restart = (i_sbc_mode == MODE_RESTART);
  wire logic in_failsafe = (i_sbc_mode == MODE_FAILSAFE);

  // supply fault shutdown and mode gating
  wire logic ov_sd = ov_s && !supply_ctrl[OV_SD_DIS_BIT];
  wire logic uv_sd = uv_s && !supply_ctrl[UV_SD_DIS_BIT];
  wire logic vfault = ov_sd || uv_sd;
  wire logic vfault_end = vfault_q && !vfault;
  wire logic off_mode = in_restart || in_failsafe;
  wire logic off_entry = off_mode && !off_mode_q;
  wire logic cfg_lock = in_stop || in_sleep;
  wire logic hw_clear_all = (vfault_end && !supply_ctrl[RECOVERY_BIT]) || off_entry;

  // apb decode
  wire logic acc = i_psel && i_penable;
  wire logic wr = acc && i_pwrite;
  wire logic cfg_wr = wr && !cfg_lock;
  wire logic hit_ctrl_a = (i_paddr == ADDR_CTRL_A);
  wire logic hit_ctrl_b = (i_paddr == ADDR_CTRL_B);
  wire logic hit_pwm_a = (i_paddr == ADDR_PWM_A);
  wire logic hit_pwm_b = (i_paddr == ADDR_PWM_B);
  wire logic hit_freq = (i_paddr == ADDR_FREQ);
  wire logic hit_sctl = (i_paddr == ADDR_SUPPLY_CTRL);
  wire logic hit_sstat = (i_paddr == ADDR_SUPPLY_STAT);
  wire logic hit_oc = (i_paddr == ADDR_OC_STAT);
  wire logic hit_ol = (i_paddr == ADDR_OL_STAT);
  wire logic mapped = hit_ctrl_a || hit_ctrl_b || hit_pwm_a || hit_pwm_b || hit_freq
                      || hit_sctl || hit_sstat || hit_oc || hit_ol;

  // write strobes; settings honour the lock, status clears never do
  wire logic wr_ctrl_a = cfg_wr && hit_ctrl_a;
  wire logic wr_ctrl_b = cfg_wr && hit_ctrl_b;
  wire logic wr_pwm_a = cfg_wr && hit_pwm_a;
  wire logic wr_pwm_b = cfg_wr && hit_pwm_b;
  wire logic wr_freq = cfg_wr && hit_freq;
  wire logic wr_sctl = cfg_wr && hit_sctl;
  wire logic wr_sstat = wr && hit_sstat;
  wire logic wr_oc = wr && hit_oc;
  wire logic wr_ol = wr && hit_ol;
  wire logic [1:0] supply_clr = wr_sstat ? i_pwdata[1:0] : 2'h0;
  wire logic [3:0] oc_clr = wr_oc ? i_pwdata[3:0] : 4'h0;
  wire logic [3:0] ol_clr = wr_ol ? i_pwdata[3:0] : 4'h0;

  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;

  // read data selection
  wire logic [31:0] rd_mux =
    hit_ctrl_a ? {25'h0, cfg[1], 1'b0, cfg[0]} :
    hit_ctrl_b ? {25'h0, cfg[3], 1'b0, cfg[2]} :
    hit_pwm_a ? {24'h0, duty_a} :
    hit_pwm_b ? {24'h0, duty_b} :
    hit_freq ? {30'h0, freq_sel} :
    hit_sctl ? {29'h0, supply_ctrl} :
    hit_sstat ? {30'h0, supply_flag} :
    hit_oc ? {28'h0, oc_flag} :
    hit_ol ? {28'h0, ol_flag} : 32'h0;

  // read data captured in setup phase
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= rd_mux;
    end
  end

  // writable settings, frozen in stop and sleep modes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      duty_a <= RST_DUTY;
      duty_b <= RST_DUTY;
      freq_sel <= RST_FREQ;
      supply_ctrl <= RST_SUPPLY_CTRL;
    end else begin
      if (wr_pwm_a) begin
        duty_a <= i_pwdata[7:0];
      end
      if (wr_pwm_b) begin
        duty_b <= i_pwdata[7:0];
      end
      if (wr_freq) begin
        freq_sel <= i_pwdata[1:0];
      end
      if (wr_sctl) begin
        supply_ctrl <= i_pwdata[2:0];
      end
    end
  end

  // channel configs: hardware clears win over software writes
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      next_cfg[k] = cfg[k];
    end
    if (wr_ctrl_a) begin
      next_cfg[0] = i_pwdata[CH_LO_LSB +: 3];
      next_cfg[1] = i_pwdata[CH_HI_LSB +: 3];
    end
    if (wr_ctrl_b) begin
      next_cfg[2] = i_pwdata[CH_LO_LSB +: 3];
      next_cfg[3] = i_pwdata[CH_HI_LSB +: 3];
    end
    for (int k = 0; k < 4; k++) begin
      if (oc_trip[k] || hw_clear_all) begin
        next_cfg[k] = CFG_OFF;
      end
    end
  end

  // config storage and edge history
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < 4; k++) begin
        cfg[k] <= RST_CFG;
      end
      vfault_q <= 1'b0;
      off_mode_q <= 1'b0;
    end else begin
      cfg <= next_cfg;
      vfault_q <= vfault;
      off_mode_q <= off_mode;
    end
  end

  // supply flags, set wins over clear; no channel flag is touched
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      supply_flag <= 2'h0;
    end else begin
      supply_flag[OV_FLAG_BIT] <= (supply_flag[OV_FLAG_BIT] && !supply_clr[OV_FLAG_BIT]) || ov_s;
      supply_flag[UV_FLAG_BIT] <= (supply_flag[UV_FLAG_BIT] && !supply_clr[UV_FLAG_BIT]) || uv_s;
    end
  end

  // per channel source selection, filters and flags
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_ch
      logic [10:0] oc_cnt;
      logic [10:0] ol_cnt;

      // configuration decode; codes 110 and 111 select nothing
      wire logic sel_on = (cfg[ch] == CFG_ON);
      wire logic sel_t1 = (cfg[ch] == CFG_TIMER1);
      wire logic sel_t2 = (cfg[ch] == CFG_TIMER2);
      wire logic sel_pa = (cfg[ch] == CFG_PWM_A);
      wire logic sel_pb = (cfg[ch] == CFG_PWM_B);

      // source mux, pwm takes effect as soon as selected
      assign source_on[ch] =
        sel_on ||
        (sel_t1 && i_timer1) ||
        (sel_t2 && i_timer2) ||
        (sel_pa && pwm_a_if.wave) ||
        (sel_pb && pwm_b_if.wave);
      // forced off during supply faults and off modes only
      assign drive[ch] = source_on[ch] && !vfault && !off_mode;
      assign oc_trip[ch] = drive[ch] && oc_s[ch] && (oc_cnt == OC_CNT_LAST);
      assign ol_trip[ch] = drive[ch] && ol_s[ch] && (ol_cnt == OL_CNT_LAST);

      // overcurrent filter, restarts when current drops or output off
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !(drive[ch] && oc_s[ch]) || oc_trip[ch]) begin
          oc_cnt <= 11'h000;
        end else begin
          oc_cnt <= oc_cnt + 11'h001;
        end
      end

      // open load filter, only while on
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !(drive[ch] && ol_s[ch])) begin
          ol_cnt <= 11'h000;
        end else if (!ol_trip[ch]) begin
          ol_cnt <= ol_cnt + 11'h001;
        end
      end

      // sticky flags, cleared only by software, set wins
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          oc_flag[ch] <= 1'b0;
          ol_flag[ch] <= 1'b0;
        end else begin
          oc_flag[ch] <= (oc_flag[ch] && !oc_clr[ch]) || oc_trip[ch];
          ol_flag[ch] <= (ol_flag[ch] && !ol_clr[ch]) || ol_trip[ch];
        end
      end

      // output driver flop; open load leaves it on
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          o_switch_output[ch] <= 1'b0;
        end else begin
          o_switch_output[ch] <= drive[ch] && !oc_trip[ch];
        end
      end
    end
  endgenerate
endmodule

// file: load_model.sv
// current sense levels of the four loads seen by the switch block
`timescale 1ns/1ps
module load_model (
  input wire logic [3:0] i_drive,
  input wire logic [3:0] i_short,
  input wire logic [3:0] i_open,
  output logic [3:0] o_overcurrent,
  output logic [3:0] o_open_load
);
  // no current flows through a switch that is off, so it reads as open
  assign o_overcurrent = i_drive & i_short;
  assign o_open_load = ~i_drive | i_open;
endmodule

// file: hs_ctl_sva.sv
// port assertions for the high-side switch control block
`timescale 1ns/1ps
module hs_ctl_sva (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire hs_pkg::mode_t i_sbc_mode,
  input wire logic [3:0] i_overcurrent,
  input wire logic [3:0] o_switch_output
);
  import hs_pkg::*;
  logic [9:0] oc_run;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // cycles channel 0 has stayed on into a short
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !(o_switch_output[0] && i_overcurrent[0])) oc_run <= 10'h0;
    else if (oc_run != 10'h3ff) oc_run <= oc_run + 10'h1;
  end
  pready_high_a: assert property (o_pready) else $error("pready low");
  slverr_phase_a: assert property (o_pslverr |-> i_psel && i_penable) else $error("pslverr outside access");
  slverr_unmapped_a: assert property (i_psel && i_penable && i_paddr > 8'h20 |-> o_pslverr)
    else $error("no error on unmapped");
  slverr_mapped_a: assert property (i_psel && i_penable && i_paddr[1:0] == 2'h0 && i_paddr <= 8'h20 |-> !o_pslverr)
    else $error("error on mapped");
  unmapped_zero_a: assert property (i_psel && i_penable && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (i_psel && i_penable |=> $stable(o_prdata)) else $error("read data moved");
  offmode_off_a: assert property (i_sbc_mode inside {MODE_RESTART, MODE_FAILSAFE} |=> o_switch_output == 4'h0)
    else $error("output on in off mode");
  reset_off_a: assert property ($fell(i_sys_rst) |-> o_switch_output == 4'h0 && o_prdata == 32'h0)
    else $error("outputs not cleared by reset");
  oc_limit_a: assert property (oc_run < 10'd306) else $error("short not switched off");
endmodule
bind high_side_switch_control hs_ctl_sva hs_ctl_sva_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sbc_mode(i_sbc_mode), .i_overcurrent(i_overcurrent),
  .o_switch_output(o_switch_output));

// file: high_side_switch_control_bench.sv
// self-checking bench for the high-side switch control block
`timescale 1ns/1ps
module high_side_switch_control_bench;
  import hs_pkg::*;
  logic clk, rst, psel, penable, pwrite, ov, uv, t1, t2, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] oc, ol, sw, short_m, open_m;
  mode_t mode;
  int failures, tests_run, n;
  logic [7:0] row_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24};
  logic [31:0] row_d [6] = '{32'hffff, 32'h55, 32'h1aa, 32'h3, 32'hff, 32'hff};
  logic [31:0] row_q [6] = '{32'h77, 32'h55, 32'haa, 32'h3, 32'h3, 32'h0};
  high_side_switch_control high_side_switch_control_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sbc_mode(mode), .i_supply_ov(ov), .i_supply_uv(uv),
    .i_overcurrent(oc), .i_open_load(ol), .i_timer1(t1), .i_timer2(t2), .o_switch_output(sw));
  load_model load_model_inst (.i_drive(sw), .i_short(short_m), .i_open(open_m), .o_overcurrent(oc),
    .o_open_load(ol));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic sw0(input logic x);
    chk({31'h0, sw[0]}, {31'h0, x});
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mode = MODE_NORMAL;
    ov = 1'b0;
    uv = 1'b0;
    t1 = 1'b0;
    t2 = 1'b0;
    short_m = 4'h0;
    open_m = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i <= 8; i++) rd(8'(4 * i), 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(row_a[i], row_d[i]);
      rd(row_a[i], row_q[i]);
      chk({31'h0, e}, {31'h0, i == 5});
    end
    $display("registers done");
    // timers, direct control and a 400 hz generator side by side
    wr(ADDR_PWM_A, 32'h80);
    wr(ADDR_FREQ, 32'h1);
    wr(ADDR_CTRL_A, 32'h21);
    wr(ADDR_CTRL_B, 32'h43);
    t1 <= 1'b1;
    tick(4);
    chk({29'h0, sw[2:0]}, 32'h3);
    t1 <= 1'b0;
    t2 <= 1'b1;
    tick(4);
    chk({29'h0, sw[2:0]}, 32'h5);
    n = 0;
    repeat (STEP_FAST_CYCLES * PWM_STEPS) begin
      @(posedge clk);
      n += (sw[3] === 1'b1);
    end
    chk(32'(n), 32'(128 * STEP_FAST_CYCLES));
    $display("sources done");
    wr(ADDR_CTRL_B, 32'h0);
    wr(ADDR_CTRL_A, 32'h1);
    ov <= 1'b1;
    tick(5);
    sw0(1'b0);
    rd(ADDR_SUPPLY_STAT, 32'h1);
    rd(ADDR_OC_STAT, 32'h0);
    rd(ADDR_OL_STAT, 32'h0);
    ov <= 1'b0;
    tick(5);
    sw0(1'b0);
    rd(ADDR_CTRL_A, 32'h0);
    wr(ADDR_SUPPLY_STAT, 32'h3);
    wr(ADDR_SUPPLY_CTRL, 32'h4);
    wr(ADDR_CTRL_A, 32'h1);
    uv <= 1'b1;
    tick(5);
    sw0(1'b0);
    uv <= 1'b0;
    tick(5);
    sw0(1'b1);
    wr(ADDR_SUPPLY_CTRL, 32'h5);
    ov <= 1'b1;
    tick(5);
    sw0(1'b1);
    ov <= 1'b0;
    $display("supply done");
    // short on channel 0: switched off after the filter time
    short_m <= 4'h1;
    n = 0;
    while (sw[0] === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= 300 && n <= 305}, 32'h1);
    if (n >= 400) conclude();
    tick(20);
    rd(ADDR_OC_STAT, 32'h1);
    rd(ADDR_CTRL_A, 32'h0);
    short_m <= 4'h0;
    wr(ADDR_OC_STAT, 32'h1);
    rd(ADDR_OC_STAT, 32'h0);
    wr(ADDR_CTRL_A, 32'h1);
    tick(4);
    sw0(1'b1);
    open_m <= 4'h1;
    tick(1500);
    rd(ADDR_OL_STAT, 32'h0);
    tick(200);
    rd(ADDR_OL_STAT, 32'h1);
    sw0(1'b1);
    open_m <= 4'h0;
    wr(ADDR_OL_STAT, 32'h1);
    rd(ADDR_OL_STAT, 32'h0);
    $display("load faults done");
    // configuration lock in stop, switch-off in restart and fail-safe
    mode <= MODE_STOP;
    wr(ADDR_CTRL_A, 32'h0);
    tick(4);
    sw0(1'b1);
    rd(ADDR_CTRL_A, 32'h1);
    uv <= 1'b1;
    tick(5);
    sw0(1'b0);
    uv <= 1'b0;
    tick(5);
    sw0(1'b1);
    mode <= MODE_RESTART;
    tick(3);
    chk({28'h0, sw}, 32'h0);
    rd(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_A, 32'h1);
    mode <= MODE_NORMAL;
    tick(4);
    sw0(1'b1);
    mode <= MODE_FAILSAFE;
    tick(3);
    sw0(1'b0);
    $display("modes done");
    // lock in sleep, then a mid-run reset while an output is on
    mode <= MODE_NORMAL;
    wr(ADDR_CTRL_A, 32'h1);
    mode <= MODE_SLEEP;
    wr(ADDR_CTRL_A, 32'h0);
    tick(4);
    sw0(1'b1);
    rd(ADDR_CTRL_A, 32'h1);
    mode <= MODE_NORMAL;
    rst <= 1'b1;
    tick(2);
    sw0(1'b0);
    rst <= 1'b0;
    // duty 1 at 200 hz from reset: high through the first step only
    wr(ADDR_PWM_B, 32'h1);
    wr(ADDR_CTRL_B, 32'h5);
    tick(STEP_FAST_CYCLES);
    chk({31'h0, sw[2]}, 32'h1);
    tick(STEP_SLOW_CYCLES - STEP_FAST_CYCLES);
    chk({31'h0, sw[2]}, 32'h0);
    rd(ADDR_SUPPLY_CTRL, 32'h0);
    rd(ADDR_CTRL_A, 32'h0);
    $display("sleep and reset done");
    conclude();
  end
  // cuts a hang short
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
